// ---- rtl/spsr_pkg.sv ----
// constants and carrier types for the socket present state register block
// assumes a single host clock domain; pins arrive raw from the socket
package spsr_pkg;

	// -----------------------------------------------------------------
	// register offsets on the plain register port
	// -----------------------------------------------------------------
	localparam logic [7:0] SPSR_OFS_STATUS = 8'h08; // status snapshot
	localparam logic [7:0] SPSR_OFS_FORCE  = 8'h0c; // force register

	// -----------------------------------------------------------------
	// field positions inside the status and force words
	// -----------------------------------------------------------------
	localparam int SPSR_BIT_VCC_Y    = 31; // socket can supply y.y volts
	localparam int SPSR_BIT_VCC_X    = 30; // socket can supply x.x volts
	localparam int SPSR_BIT_VCC_LOW  = 29; // socket can supply 3.3 volts
	localparam int SPSR_BIT_VCC_HIGH = 28; // socket can supply 5 volts
	localparam int SPSR_BIT_ZOOM     = 27; // zoomed video support
	localparam int SPSR_BIT_RSV_HI   = 26; // reserved span top
	localparam int SPSR_BIT_REINT    = 14; // force: re-interrogate card
	localparam int SPSR_BIT_ACC_HI   = 13; // card accepts y.y volts
	localparam int SPSR_BIT_ACC_LO   = 10; // card accepts 5 volts
	localparam int SPSR_BIT_BAD_REQ  = 9;  // invalid supply request
	localparam int SPSR_BIT_LOSS     = 8;  // removal may have lost data
	localparam int SPSR_BIT_UNREC    = 7;  // unrecognized card
	localparam int SPSR_BIT_READY    = 6;  // ready/irq pin level
	localparam int SPSR_BIT_BUS32    = 5;  // 32-bit bus master card
	localparam int SPSR_BIT_NARROW   = 4;  // 16-bit card
	localparam int SPSR_BIT_POWERED  = 3;  // socket powered up
	localparam int SPSR_BIT_DET_TWO  = 2;  // detect pin two level
	localparam int SPSR_BIT_DET_ONE  = 1;  // detect pin one level
	localparam int SPSR_BIT_STATUS   = 0;  // status change pin level

	// -----------------------------------------------------------------
	// values after reset
	// -----------------------------------------------------------------
	localparam logic [31:0] SPSR_RST_STATUS = 32'h3000_0000;
	// pin image after reset: {ready, detect two, detect one, status}
	localparam logic [3:0]  SPSR_RST_PINS   = 4'h6;
	localparam logic        SPSR_RST_PWR_EN = 1'h1; // power control on

	// -----------------------------------------------------------------
	// carrier types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic ready_irq;     // ready/irq pin, raw
		logic detect_two;    // card detect pin two, raw, low = card
		logic detect_one;    // card detect pin one, raw, low = card
		logic status_change; // status change pin, raw
	} spsr_pins_t;

	typedef struct packed {
		logic       unrecognized; // interrogation found no valid card
		logic       bus32;        // 32-bit bus master card
		logic       narrow;       // 16-bit card
		logic [3:0] accepts;      // {y.y, x.x, 3.3, 5} volt acceptance
	} spsr_card_t;

endpackage : spsr_pkg

// ---- rtl/spsr_status.sv ----
// socket present state register: live pin levels, card type, supply
// capability and error flags, read by host software at one offset
// assumes the interrogation sequencer and power switch logic run on
// core_clk_in; only the socket pins come from outside the clock domain
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps

module spsr_status (
	input  wire logic               core_clk_in,      // host clock
	input  wire logic               rstn_in,          // async reset, low
	input  wire logic [7:0]         addr_in,          // register address
	input  wire logic [31:0]        wdata_in,         // write data
	input  wire logic               wr_in,            // write strobe
	input  wire logic               rd_in,            // read strobe
	output logic      [31:0]        rdata_out,        // read data
	input  wire spsr_pkg::spsr_pins_t pins_in,        // raw socket pins
	input  wire logic               interrogating_in, // identification busy
	input  wire logic               interrogate_done_in, // result pulse
	input  wire spsr_pkg::spsr_card_t card_in,        // identification result
	input  wire logic               powered_in,       // socket power is up
	input  wire logic               bad_request_in,   // invalid request pulse
	input  wire logic               removal_loss_in,  // data loss pulse
	input  wire logic               vcc_high_override_in, // 5 v disable
	output logic                    status_event_out, // status event pulse
	output logic                    reinterrogate_out, // re-interrogate pulse
	output logic                    power_ctrl_en_out // power control enabled
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [3:0]  pin_meta;              // first sync stage, read by stage 2 only
	logic [3:0]  pin_sync;              // second sync stage
	logic        sock_vcc_y_capable;
	logic        sock_vcc_x_capable;
	logic        sock_vcc_low_capable;
	logic        sock_vcc_high_capable;
	logic        zoom_video_capable;
	logic [3:0]  card_accepts;          // {y, x, low, high}
	logic        invalid_supply_request;
	logic        removal_loss_flag;
	logic        unrecognized_card_flag;
	logic        ready_irq_pin_level;
	logic        bus32_card_detected;
	logic        narrow_card_detected;
	logic        socket_powered_flag;
	logic        detect_pin_two_level;
	logic        detect_pin_one_level;
	logic        status_change_pin_level;
	logic        force_wr;
	logic        status_rise;
	logic        status_fall;
	logic [31:0] snapshot;
	logic [3:0]  pins_vec;

	assign pins_vec = pins_in;

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	// one two-stage chain per pin; reset images assume an empty socket
	for (genvar i = 0; i < 4; i++) begin : g_sync
		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				pin_meta[i] <= spsr_pkg::SPSR_RST_PINS[i];
				pin_sync[i] <= spsr_pkg::SPSR_RST_PINS[i];
			end else begin
				pin_meta[i] <= pins_vec[i];
				pin_sync[i] <= pin_meta[i];
			end
		end
	end

	// -----------------------------------------------------------------
	// register port decode
	// -----------------------------------------------------------------
	assign force_wr = wr_in && (addr_in == spsr_pkg::SPSR_OFS_FORCE);

	// -----------------------------------------------------------------
	// socket capability fields
	// -----------------------------------------------------------------
	// the unsupported voltages stay zero; only a force write moves them
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sock_vcc_y_capable <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_VCC_Y];
			sock_vcc_x_capable <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_VCC_X];
			sock_vcc_low_capable <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_VCC_LOW];
		end else if (force_wr) begin
			sock_vcc_y_capable   <= wdata_in[spsr_pkg::SPSR_BIT_VCC_Y];
			sock_vcc_x_capable   <= wdata_in[spsr_pkg::SPSR_BIT_VCC_X];
			sock_vcc_low_capable <= wdata_in[spsr_pkg::SPSR_BIT_VCC_LOW];
		end
	end

	// 5 v capability tracks the device control override every cycle
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sock_vcc_high_capable <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_VCC_HIGH];
		end else begin
			sock_vcc_high_capable <= !vcc_high_override_in;
		end
	end

	// zoomed video support is whatever software last forced
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			zoom_video_capable <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_ZOOM];
		end else if (force_wr) begin
			zoom_video_capable <= wdata_in[spsr_pkg::SPSR_BIT_ZOOM];
		end
	end

	// -----------------------------------------------------------------
	// card fields, refreshed by interrogation
	// -----------------------------------------------------------------
	// a force write of one sets an acceptance bit; a zero leaves it, so
	// software cannot hide a voltage the card really reported
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			card_accepts <= spsr_pkg::SPSR_RST_STATUS[
				spsr_pkg::SPSR_BIT_ACC_HI:spsr_pkg::SPSR_BIT_ACC_LO];
		end else begin
			card_accepts <= (interrogate_done_in ? card_in.accepts
				: card_accepts)
				| (force_wr ? wdata_in[spsr_pkg::SPSR_BIT_ACC_HI:
					spsr_pkg::SPSR_BIT_ACC_LO] : 4'h0);
		end
	end

	// card type changes only on a new interrogation or a force write
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus32_card_detected <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_BUS32];
			narrow_card_detected <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_NARROW];
		end else if (interrogate_done_in) begin
			bus32_card_detected  <= card_in.bus32;
			narrow_card_detected <= card_in.narrow;
		end else if (force_wr) begin
			bus32_card_detected  <= wdata_in[spsr_pkg::SPSR_BIT_BUS32];
			narrow_card_detected <= wdata_in[spsr_pkg::SPSR_BIT_NARROW];
		end
	end

	// an unrecognized result sets the flag ahead of any force write;
	// only a valid card or software clears it again
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			unrecognized_card_flag <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_UNREC];
		end else if (interrogate_done_in && card_in.unrecognized) begin
			unrecognized_card_flag <= 1'b1;
		end else if (force_wr) begin
			unrecognized_card_flag <= wdata_in[spsr_pkg::SPSR_BIT_UNREC];
		end else if (interrogate_done_in) begin
			unrecognized_card_flag <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// error flags
	// -----------------------------------------------------------------
	// hardware set wins over a force write in the same cycle
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			invalid_supply_request <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_BAD_REQ];
		end else if (bad_request_in) begin
			invalid_supply_request <= 1'b1;
		end else if (force_wr) begin
			invalid_supply_request <= wdata_in[spsr_pkg::SPSR_BIT_BAD_REQ];
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			removal_loss_flag <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_LOSS];
		end else if (removal_loss_in) begin
			removal_loss_flag <= 1'b1;
		end else if (force_wr) begin
			removal_loss_flag <= wdata_in[spsr_pkg::SPSR_BIT_LOSS];
		end
	end

	// -----------------------------------------------------------------
	// power and live pin levels
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			socket_powered_flag <=
				spsr_pkg::SPSR_RST_STATUS[spsr_pkg::SPSR_BIT_POWERED];
		end else begin
			socket_powered_flag <= powered_in;
		end
	end

	// detect levels freeze during identification, since the sequencer
	// drives those pins itself and would look like a removal
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ready_irq_pin_level     <= spsr_pkg::SPSR_RST_PINS[3];
			detect_pin_two_level    <= spsr_pkg::SPSR_RST_PINS[2];
			detect_pin_one_level    <= spsr_pkg::SPSR_RST_PINS[1];
			status_change_pin_level <= spsr_pkg::SPSR_RST_PINS[0];
		end else begin
			ready_irq_pin_level     <= pin_sync[3];
			status_change_pin_level <= pin_sync[0];
			if (!interrogating_in) begin
				detect_pin_two_level <= pin_sync[2];
				detect_pin_one_level <= pin_sync[1];
			end
		end
	end

	// -----------------------------------------------------------------
	// status change event
	// -----------------------------------------------------------------
	// edges compare the synced level with its registered copy
	assign status_rise = pin_sync[0] && !status_change_pin_level;
	assign status_fall = !pin_sync[0] && status_change_pin_level;

	// with no card type known only rising edges count
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_event_out <= 1'b0;
		end else if (narrow_card_detected && !bus32_card_detected) begin
			status_event_out <= status_rise || status_fall;
		end else begin
			status_event_out <= status_rise;
		end
	end

	// -----------------------------------------------------------------
	// re-interrogation and power control enable
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reinterrogate_out <= 1'b0;
		end else begin
			reinterrogate_out <= force_wr
				&& wdata_in[spsr_pkg::SPSR_BIT_REINT];
		end
	end

	// forcing a card voltage disables power control until a retest
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			power_ctrl_en_out <= spsr_pkg::SPSR_RST_PWR_EN;
		end else if (force_wr && wdata_in[spsr_pkg::SPSR_BIT_REINT]) begin
			power_ctrl_en_out <= 1'b1;
		end else if (force_wr && (|wdata_in[spsr_pkg::SPSR_BIT_ACC_HI:
				spsr_pkg::SPSR_BIT_ACC_LO])) begin
			power_ctrl_en_out <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------
	assign snapshot = {sock_vcc_y_capable, sock_vcc_x_capable,
		sock_vcc_low_capable, sock_vcc_high_capable, zoom_video_capable,
		13'h0000,
		card_accepts, invalid_supply_request, removal_loss_flag,
		unrecognized_card_flag, ready_irq_pin_level, bus32_card_detected,
		narrow_card_detected, socket_powered_flag, detect_pin_two_level,
		detect_pin_one_level, status_change_pin_level};

	// the force register is write-only and every other address reads 0
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in && (addr_in == spsr_pkg::SPSR_OFS_STATUS)) begin
			rdata_out <= snapshot;
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	a_read_snapshot: assert property (
		rd_in && addr_in == spsr_pkg::SPSR_OFS_STATUS
		|=> rdata_out == $past(snapshot))
		else $error("status read did not return the snapshot");

	a_idle_read_zero: assert property (
		!rd_in |=> rdata_out == 32'h0000_0000)
		else $error("read data not zero outside a read");

	a_reserved_zero: assert property (
		rdata_out[spsr_pkg::SPSR_BIT_RSV_HI:spsr_pkg::SPSR_BIT_REINT] == 0)
		else $error("reserved status bits read nonzero");

	a_zoom_force: assert property (
		force_wr |=> zoom_video_capable == $past(wdata_in[27]))
		else $error("zoom support did not take forced value");

	a_cap_hold: assert property (
		!force_wr |=> $stable({sock_vcc_y_capable, sock_vcc_x_capable,
			sock_vcc_low_capable}))
		else $error("socket capability moved without force write");

	a_high_cap: assert property (
		##1 sock_vcc_high_capable == !$past(vcc_high_override_in))
		else $error("5 v capability does not follow override");

	a_accept_set: assert property (
		force_wr && wdata_in[10] ##1 !force_wr && !interrogate_done_in
		|-> card_accepts[0])
		else $error("forced 5 v acceptance did not stick");

	a_card_hold: assert property (
		!interrogate_done_in && !force_wr
		|=> $stable({card_accepts, bus32_card_detected,
			narrow_card_detected}))
		else $error("card fields changed between insertions");

	a_type_load: assert property (
		interrogate_done_in |=> bus32_card_detected == $past(card_in.bus32)
			&& narrow_card_detected == $past(card_in.narrow))
		else $error("card type not loaded from interrogation");

	a_detect_freeze: assert property (
		interrogating_in |=> $stable({detect_pin_two_level,
			detect_pin_one_level}))
		else $error("detect level moved during identification");

	a_detect_follow: assert property (
		!pins_in.detect_one && !interrogating_in [*3]
		|=> !detect_pin_one_level)
		else $error("detect one level does not follow pin");

	a_ready_follow: assert property (
		pins_in.ready_irq [*3] |=> ready_irq_pin_level)
		else $error("ready level does not follow pin");

	a_status_follow: assert property (
		!pins_in.status_change [*3] |=> !status_change_pin_level)
		else $error("status level does not follow pin");

	a_bad_req: assert property (
		bad_request_in |=> invalid_supply_request)
		else $error("invalid request flag not set");

	a_loss_set: assert property (
		removal_loss_in |=> removal_loss_flag)
		else $error("data loss flag not set");

	a_unrec_set: assert property (
		interrogate_done_in && card_in.unrecognized
		|=> unrecognized_card_flag)
		else $error("unrecognized card flag not set");

	a_powered: assert property (
		##1 socket_powered_flag == $past(powered_in))
		else $error("powered flag does not follow power state");

	a_event_fall: assert property (
		bus32_card_detected && status_fall |=> !status_event_out)
		else $error("falling edge raised event on 32-bit card");

	a_event_rise: assert property (
		status_rise |=> status_event_out)
		else $error("rising edge did not raise event");

	a_retest: assert property (
		force_wr && wdata_in[14]
		|=> reinterrogate_out && power_ctrl_en_out
			##1 !reinterrogate_out || $past(force_wr))
		else $error("retest did not pulse and re-enable power");

	c_insert: cover property (interrogate_done_in && card_in.bus32);
	c_narrow_fall: cover property (narrow_card_detected && status_fall
		##1 status_event_out);
	c_status_read: cover property (rd_in
		&& addr_in == spsr_pkg::SPSR_OFS_STATUS ##1 rdata_out[1]);
	c_retest: cover property (force_wr && wdata_in[14]);

endmodule : spsr_status

// ---- test/spsr_card_model.sv ----
// behavioural card seated in the socket: pin levels and the result of
// identification; assumes the bench sets presence, levels and card kind
`timescale 1ns/10ps

module spsr_card_model (
	input  wire logic                 core_clk_in, // host clock
	input  wire logic                 rstn_in,     // async reset, low
	input  wire logic                 present_in,  // card seated
	input  wire logic                 irq_in,      // ready/irq level
	input  wire logic                 sts_in,      // status change level
	input  wire spsr_pkg::spsr_card_t kind_in,     // card to report
	output spsr_pkg::spsr_pins_t      pins_out,    // socket pins
	output logic                      busy_out,    // identification runs
	output logic                      done_out,    // result pulse
	output spsr_pkg::spsr_card_t      card_out     // identification result
);
	logic       was; // presence one cycle ago
	logic [3:0] cnt; // identification cycles left
	logic       gone; // detect pins high: no card or not yet seated

	// -----------------------------------------------------------------
	// identification lasts eight cycles, result on the last one
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			was <= 1'h0;
			cnt <= 4'h0;
		end else begin
			was <= present_in;
			if (present_in && !was)
				cnt <= 4'h8;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
	assign busy_out = cnt != 4'h0;
	assign done_out = cnt == 4'h1;
	assign card_out = kind_in;
	// detect pins fall mid-identification, so a missing hold shows up
	assign gone = !(present_in && was && cnt < 4'h7);
	// one driver for the whole pin bundle: {ready, two, one, status}
	assign pins_out = {irq_in, gone, gone, sts_in};
endmodule : spsr_card_model

// ---- test/spsr_status_test.sv ----
// self-checking bench for the socket present state register
// assumes the card model beside it and a 125 MHz host clock
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end

module spsr_status_test;
	logic                 core_clk_in = 1'b0;
	logic                 rstn_in     = 1'b0;
	logic [7:0]           addr        = 8'h00;
	logic [31:0]          wdata       = 32'h0000_0000;
	logic [31:0]          rdata;
	logic                 wr = 0, rd = 0, present = 0, irq = 0, sts = 0;
	logic                 powered = 0, bad = 0, loss = 0, ovr = 0;
	logic                 busy, done, ev, reint, pwr_en;
	spsr_pkg::spsr_pins_t pins;
	spsr_pkg::spsr_card_t card;
	spsr_pkg::spsr_card_t kind = 7'h13; // 16-bit card, 3.3 v and 5 v
	int                   n_errors = 0, n_compared = 0;
	int                   n_ev = 0, n_reint = 0;

	spsr_status i_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .pins_in(pins), .interrogating_in(busy),
		.interrogate_done_in(done), .card_in(card), .powered_in(powered),
		.bad_request_in(bad), .removal_loss_in(loss),
		.vcc_high_override_in(ovr), .status_event_out(ev),
		.reinterrogate_out(reint), .power_ctrl_en_out(pwr_en));
	spsr_card_model i_card (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.present_in(present), .irq_in(irq), .sts_in(sts), .kind_in(kind),
		.pins_out(pins), .busy_out(busy), .done_out(done), .card_out(card));

	// -----------------------------------------------------------------
	// clock and pulse counters; pulses stand one cycle so count per edge
	// -----------------------------------------------------------------
	initial forever #4 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		if (ev === 1'b1) n_ev++;
		if (reint === 1'b1) n_reint++;
	end

	// -----------------------------------------------------------------
	// register port and waiting helpers
	// -----------------------------------------------------------------
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk_in);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask : rd_chk
	task automatic wr_reg(input logic [31:0] d);
		@(posedge core_clk_in);
		wr <= 1'b1;
		addr <= spsr_pkg::SPSR_OFS_FORCE;
		wdata <= d;
		@(posedge core_clk_in);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic wait_idle;
		for (int i = 0; i < 50 && busy === 1'b1; i++)
			@(posedge core_clk_in);
		if (busy !== 1'b0) begin
			n_errors++;
			report_and_stop;
		end
	endtask : wait_idle
	task automatic report_and_stop;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_reset;
		rd_chk(8'h08, 32'h3000_0006);
		rd_chk(8'h0c, 32'h0000_0000);
		rd_chk(8'h10, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset
	// no card kind known yet, so only the rising edge raises an event
	task automatic t_pins;
		@(posedge core_clk_in);
		irq <= 1'b1;
		sts <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		rd_chk(8'h08, 32'h3000_0047);
		`CHK(n_ev, 1)
		@(posedge core_clk_in);
		sts <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		`CHK(n_ev, 1)
		$display("test pins done");
	endtask : t_pins
	task automatic t_insert;
		present <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		rd_chk(8'h08, 32'h3000_0046);
		wait_idle;
		repeat (4) @(posedge core_clk_in);
		rd_chk(8'h08, 32'h3000_0c50);
		@(posedge core_clk_in);
		sts <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		sts <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		`CHK(n_ev, 3)
		$display("test insert done");
	endtask : t_insert
	task automatic t_force;
		wr_reg(32'h8800_2300);
		`CHK(pwr_en, 1'b0)
		rd_chk(8'h08, 32'h9800_2f40);
		`CHK(n_reint, 0)
		wr_reg(32'h2000_4000);
		`CHK(pwr_en, 1'b1)
		rd_chk(8'h08, 32'h3000_2c40);
		`CHK(n_reint, 1)
		$display("test force done");
	endtask : t_force
	// flag pulses last one cycle; the flags must hold afterwards
	task automatic t_misc;
		@(posedge core_clk_in);
		ovr <= 1'b1;
		powered <= 1'b1;
		bad <= 1'b1;
		loss <= 1'b1;
		@(posedge core_clk_in);
		bad <= 1'b0;
		loss <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rd_chk(8'h08, 32'h2000_2f48);
		$display("test misc done");
	endtask : t_misc
	// an unrecognized 32-bit card replaces the first: old card fields
	// hold over the removal, and only rising edges raise events now
	task automatic t_swap;
		@(posedge core_clk_in);
		present <= 1'b0;
		kind <= 7'h60;
		repeat (4) @(posedge core_clk_in);
		rd_chk(8'h08, 32'h2000_2f4e);
		@(posedge core_clk_in);
		present <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		wait_idle;
		repeat (4) @(posedge core_clk_in);
		rd_chk(8'h08, 32'h2000_03e8);
		@(posedge core_clk_in);
		sts <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		sts <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		`CHK(n_ev, 4)
		$display("test swap done");
	endtask : t_swap

	initial begin
		repeat (3) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		t_reset;
		t_pins;
		t_insert;
		t_force;
		t_misc;
		t_swap;
		report_and_stop;
	end
endmodule : spsr_status_test
